// *** verilog/pfs_pkg.sv ***
package pfs_pkg;
   // clock and time base
   localparam int CLK_HZ          = 100_000_000;
   localparam int TICK_US         = 1;
   localparam int TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
   // recovery and delay times in ms
   localparam int HYST_RETRY_MS   = 1000;
   localparam int DLY_0_MS        = 0;
   localparam int DLY_1_MS        = 500;
   localparam int DLY_2_MS        = 1000;
   localparam int DLY_3_MS        = 2000;
   localparam int SS_0_MS         = 10;
   localparam int SS_1_MS         = 20;
   localparam int SS_2_MS         = 40;
   localparam int SS_3_MS         = 80;
   localparam int US_PER_MS       = 1000;
   // flag count and field widths
   localparam int NFLAG           = 8;
   localparam int DB_W            = 8;
   localparam int DUTY_W          = 8;
   localparam int TMR_W           = 32;
   // flag indices with fixed meaning
   localparam int FLAG_ACC_OC     = 0;
   // action codes
   localparam logic [1:0] ACT_IGNORE = 2'h0;
   localparam logic [1:0] ACT_SR_OFF = 2'h1;
   localparam logic [1:0] ACT_OR_OFF = 2'h2;
   localparam logic [1:0] ACT_PSU_OFF = 2'h3;
   // reset values
   localparam logic [DUTY_W-1:0] DUTY_RST = 8'h00;

   typedef enum logic [2:0] {
      PFS_OFF   = 3'h0,
      PFS_DELAY = 3'h1,
      PFS_SOFT  = 3'h2,
      PFS_RUN   = 3'h3,
      PFS_RETRY = 3'h4,
      PFS_LATCH = 3'h5
   } pfs_state_t;
endpackage

// *** verilog/pfs_debounce.sv ***
`timescale 1ns/10ps
module pfs_debounce #(
   parameter int DB_W = 8                 // debounce count width
) (
   input  wire logic            i_clk,    // system clock
   input  wire logic            i_rst_b,  // async reset, active low
   input  wire logic            i_tick,   // time base enable
   input  wire logic            i_flag,   // synchronised flag
   input  wire logic            i_imm,    // immediate timing selected
   input  wire logic [DB_W-1:0] i_db,     // debounce length in ticks
   output logic                 o_qual    // qualified flag
);
   typedef struct packed {
      logic [DB_W-1:0] cnt;
      logic            qual;
   } pfs_db_t;

   pfs_db_t st_r;
   pfs_db_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (!i_flag) begin
         st_nxt.cnt  = '0;
         st_nxt.qual = 1'b0;
      end else if (i_imm) begin
         st_nxt.qual = 1'b1;
      end else if (i_tick && !st_r.qual) begin
         if (st_r.cnt >= i_db) begin
            st_nxt.qual = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_qual = st_r.qual;
endmodule

// *** verilog/pfs_sequencer.sv ***
`timescale 1ns/10ps
// Overview of operation
// - after a flag asserts, wait a programmable debounce time before acting
// - every flag has its own action, timing and recovery setting; the debounce length is shared by all flags
// - action per flag: ignore, rectifiers off, oring switch off, supply off
// - per flag timing: act immediately or after debounce
// - debounced action only if flag stays set the full interval
// - record the first flag of a fault event for readout
// - per flag recovery choice: hysteretic or latching
// - hysteretic restarts after 1 s; latching waits for power-on toggle
// - start from hardware request, software bit or both, after a delay
// - turn-on delay selectable, including 0.5 s and 2 s
// - soft-start ramp on primary and rectifiers, 20 ms or 40 ms among choices
// - blanking option keeps rectifiers off through the whole ramp
// - rectifier soft start raises rectifier duty gradually over the ramp
// - soft-start-always option ramps afresh on every restart after a fault
// - pulse skipping when demanded duty is below modulation low limit
// - selectable modulating edge and modulation sense
// - fixed duty mode replaces regulated duty
// - accurate input overcurrent (flag 0) set to supply off with hysteretic recovery stops PWM, restarts after 1 s
module pfs_sequencer #(
   parameter int NFLAG = pfs_pkg::NFLAG,                  // number of flags
   parameter int DB_W  = pfs_pkg::DB_W,                   // debounce width
   parameter int DW    = pfs_pkg::DUTY_W,                 // duty width
   parameter int TICK_CYC = pfs_pkg::TICK_CYC,            // cycles per microsecond
   parameter int US_PER_MS = pfs_pkg::US_PER_MS           // ticks per ms
) (
   input  wire logic                 i_clk,               // 100 MHz clock
   input  wire logic                 i_rst_b,             // async reset, active low
   input  wire logic [NFLAG-1:0]     i_flag,              // raw protection flags
   input  wire logic [2*NFLAG-1:0]   i_action,            // 2-bit action per flag
   input  wire logic [NFLAG-1:0]     i_timing_imm,        // 1 = immediate action
   input  wire logic [NFLAG-1:0]     i_recovery_latch,    // 1 = latching recovery
   input  wire logic [DB_W-1:0]      i_debounce,          // debounce in ms
   input  wire logic                 i_power_on_request,  // hardware request pin
   input  wire logic                 i_software_power_on_bit, // software request
   input  wire logic [1:0]           i_pon_src,           // 1 hw, 2 sw, 3 both
   input  wire logic [1:0]           i_pon_delay_sel,     // turn-on delay select
   input  wire logic [1:0]           i_ss_sel,            // soft-start length select
   input  wire logic                 i_sr_blank,          // blank rectifiers in ramp
   input  wire logic                 i_sr_soft,           // rectifier fade-in
   input  wire logic                 i_ss_always,         // ramp on every restart
   input  wire logic [DW-1:0]        i_duty_demand,       // regulated duty
   input  wire logic [DW-1:0]        i_mod_low,           // modulation low limit
   input  wire logic                 i_skip_en,           // pulse skipping enable
   input  wire logic                 i_fixed_en,          // fixed duty mode
   input  wire logic [DW-1:0]        i_fixed_duty,        // fixed duty value
   input  wire logic                 i_edge_fall,         // 1 = falling edge modulates
   input  wire logic                 i_sense_neg,         // 1 = negative modulation
   input  wire logic                 i_first_clr,         // clear first-flag record
   output logic                      o_pwm_en,            // primary switching enabled
   output logic [DW-1:0]             o_pwm_duty,          // duty to pwm stage
   output logic                      o_pwm_edge_fall,     // modulating edge
   output logic                      o_pwm_sense_neg,     // modulation sense
   output logic                      o_pulse_skip,        // pulse skipping active
   output logic                      o_sync_rectifier_drive, // rectifiers enabled
   output logic [DW-1:0]             o_sr_duty,           // rectifier duty
   output logic                      o_oring_switch,      // oring switch on
   output logic [NFLAG-1:0]          o_first_flag,        // first flag one-hot
   output logic                      o_first_valid,       // record holds a flag
   output logic [2:0]                o_state              // sequencer state
);
   localparam int MS_W = 12;

   typedef struct packed {
      logic [NFLAG-1:0]      f_s1;
      logic [NFLAG-1:0]      f_s2;
      logic                  hw_s1;
      logic                  hw_s2;
      logic [7:0]            pre;
      logic [9:0]            us;
      logic                  ms_tick;
      logic [MS_W-1:0]       tmr;
      logic                  req_d;
      logic                  started;
      pfs_pkg::pfs_state_t   state;
      logic [NFLAG-1:0]      first;
      logic                  first_v;
      logic                  sr_off;
      logic                  or_off;
      logic                  pwm_en;
      logic [DW-1:0]         duty;
      logic                  skip;
      logic                  sr_on;
      logic [DW-1:0]         sr_duty;
      logic                  edge_fall;
      logic                  sense_neg;
      logic                  oring;
   } pfs_st_t;

   pfs_st_t          st_r;
   pfs_st_t          st_nxt;
   logic [NFLAG-1:0] qual;
   logic             us_tick;

   assign us_tick = (st_r.pre == 8'(TICK_CYC - 1));

   genvar g;
   generate
      for (g = 0; g < NFLAG; g++) begin : g_db
         pfs_debounce #(.DB_W(DB_W)) u_db (
            .i_clk   (i_clk),
            .i_rst_b (i_rst_b),
            .i_tick  (st_r.ms_tick),
            .i_flag  (st_r.f_s2[g]),
            .i_imm   (i_timing_imm[g]),
            .i_db    (i_debounce),
            .o_qual  (qual[g])
         );
      end
   endgenerate

   function automatic logic [MS_W-1:0] dly_ms(input logic [1:0] sel);
      case (sel)
         2'h0:    dly_ms = MS_W'(pfs_pkg::DLY_0_MS);
         2'h1:    dly_ms = MS_W'(pfs_pkg::DLY_1_MS);
         2'h2:    dly_ms = MS_W'(pfs_pkg::DLY_2_MS);
         default: dly_ms = MS_W'(pfs_pkg::DLY_3_MS);
      endcase
   endfunction

   function automatic logic [MS_W-1:0] ss_ms(input logic [1:0] sel);
      case (sel)
         2'h0:    ss_ms = MS_W'(pfs_pkg::SS_0_MS);
         2'h1:    ss_ms = MS_W'(pfs_pkg::SS_1_MS);
         2'h2:    ss_ms = MS_W'(pfs_pkg::SS_2_MS);
         default: ss_ms = MS_W'(pfs_pkg::SS_3_MS);
      endcase
   endfunction

   // fraction of full duty by ramp progress
   function automatic logic [DW-1:0] ramp(input logic [DW-1:0] full, input logic [MS_W-1:0] done,
                                          input logic [MS_W-1:0] len);
      logic [DW+MS_W-1:0] p;
      p = (DW+MS_W)'(full) * (DW+MS_W)'(done);
      if (len == '0) begin
         ramp = full;
      end else begin
         ramp = DW'(p / (DW+MS_W)'(len));
      end
   endfunction

   logic             req;
   logic             any_off;
   logic             any_latch;
   logic             any_sr;
   logic             any_or;
   logic [DW-1:0]    base;
   logic [DW-1:0]    dreg;

   always_comb begin
      req       = ((i_pon_src[0] | ~i_pon_src[1]) ? st_r.hw_s2 : 1'b1) &
                  (i_pon_src[1] ? i_software_power_on_bit : 1'b1);
      any_off   = 1'b0;
      any_latch = 1'b0;
      any_sr    = 1'b0;
      any_or    = 1'b0;
      for (int i = 0; i < NFLAG; i++) begin
         if (qual[i]) begin
            case (i_action[2*i +: 2])
               pfs_pkg::ACT_SR_OFF:  any_sr = 1'b1;
               pfs_pkg::ACT_OR_OFF:  any_or = 1'b1;
               pfs_pkg::ACT_PSU_OFF: begin
                  any_off   = 1'b1;
                  any_latch = any_latch | i_recovery_latch[i];
               end
               default:              ;
            endcase
         end
      end
      base = i_fixed_en ? i_fixed_duty : i_duty_demand;
      dreg = (i_skip_en && !i_fixed_en && (i_duty_demand < i_mod_low)) ? '0 : base;

      st_nxt           = st_r;
      st_nxt.f_s1      = i_flag;
      st_nxt.f_s2      = st_r.f_s1;
      st_nxt.hw_s1     = i_power_on_request;
      st_nxt.hw_s2     = st_r.hw_s1;
      st_nxt.pre       = us_tick ? '0 : st_r.pre + 8'h01;
      st_nxt.ms_tick   = 1'b0;
      if (us_tick) begin
         if (st_r.us == 10'(US_PER_MS - 1)) begin
            st_nxt.us      = '0;
            st_nxt.ms_tick = 1'b1;
         end else begin
            st_nxt.us = st_r.us + 10'h001;
         end
      end
      st_nxt.req_d     = req;
      st_nxt.sr_off    = any_sr;
      st_nxt.or_off    = any_or;
      st_nxt.edge_fall = i_edge_fall;
      st_nxt.sense_neg = i_sense_neg;

      // first-flag capture; a new flag wins over a clear in the same cycle if the record is empty, else it is captured a cycle later
      if (i_first_clr) begin
         st_nxt.first   = '0;
         st_nxt.first_v = 1'b0;
      end
      if (!st_r.first_v && (qual != '0)) begin
         st_nxt.first   = qual & (~qual + 1'b1);
         st_nxt.first_v = 1'b1;
      end

      case (st_r.state)
         pfs_pkg::PFS_OFF: begin
            st_nxt.tmr = '0;
            if (req && !st_r.req_d) begin
               st_nxt.state = pfs_pkg::PFS_DELAY;
            end
         end
         pfs_pkg::PFS_DELAY: begin
            if (!req) begin
               st_nxt.state = pfs_pkg::PFS_OFF;
            end else if (st_r.tmr >= dly_ms(i_pon_delay_sel)) begin
               st_nxt.tmr   = '0;
               st_nxt.state = pfs_pkg::PFS_SOFT;
            end else if (st_r.ms_tick) begin
               st_nxt.tmr = st_r.tmr + 1'b1;
            end
         end
         pfs_pkg::PFS_SOFT: begin
            if (st_r.tmr >= ss_ms(i_ss_sel)) begin
               st_nxt.state   = pfs_pkg::PFS_RUN;
               st_nxt.started = 1'b1;
            end else if (st_r.ms_tick) begin
               st_nxt.tmr = st_r.tmr + 1'b1;
            end
         end
         pfs_pkg::PFS_RUN: begin
            st_nxt.tmr = '0;
         end
         pfs_pkg::PFS_RETRY: begin
            if (st_r.tmr >= MS_W'(pfs_pkg::HYST_RETRY_MS) && !any_off) begin
               st_nxt.tmr   = '0;
               st_nxt.state = (i_ss_always || !st_r.started) ? pfs_pkg::PFS_SOFT
                                                             : pfs_pkg::PFS_RUN;
            end else if (st_r.ms_tick && st_r.tmr < MS_W'(pfs_pkg::HYST_RETRY_MS)) begin
               st_nxt.tmr = st_r.tmr + 1'b1;
            end
         end
         pfs_pkg::PFS_LATCH: begin
            if (!req) begin
               st_nxt.state = pfs_pkg::PFS_OFF;
            end
         end
         default: st_nxt.state = pfs_pkg::PFS_OFF;
      endcase

      // fault and request loss override the sequence
      if (st_r.state != pfs_pkg::PFS_OFF && st_r.state != pfs_pkg::PFS_LATCH && !req) begin
         st_nxt.state   = pfs_pkg::PFS_OFF;
         st_nxt.started = 1'b0;
      end else if (any_off && (st_r.state == pfs_pkg::PFS_SOFT || st_r.state == pfs_pkg::PFS_RUN)) begin
         st_nxt.tmr   = '0;
         st_nxt.state = any_latch ? pfs_pkg::PFS_LATCH : pfs_pkg::PFS_RETRY;
      end

      // outputs
      st_nxt.pwm_en  = 1'b0;
      st_nxt.duty    = '0;
      st_nxt.skip    = 1'b0;
      st_nxt.sr_on   = 1'b0;
      st_nxt.sr_duty = '0;
      st_nxt.oring   = 1'b0;
      if (st_r.state == pfs_pkg::PFS_SOFT) begin
         st_nxt.pwm_en  = 1'b1;
         st_nxt.duty    = ramp(base, st_r.tmr, ss_ms(i_ss_sel));
         st_nxt.sr_on   = !i_sr_blank && !any_sr;
         st_nxt.sr_duty = i_sr_soft ? ramp(base, st_r.tmr, ss_ms(i_ss_sel))
                                    : base;
         st_nxt.oring   = !any_or;
      end else if (st_r.state == pfs_pkg::PFS_RUN) begin
         st_nxt.pwm_en  = 1'b1;
         st_nxt.skip    = i_skip_en && !i_fixed_en && (i_duty_demand < i_mod_low);
         st_nxt.duty    = dreg;
         st_nxt.sr_on   = !any_sr;
         st_nxt.sr_duty = dreg;
         st_nxt.oring   = !any_or;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r       <= '0;
         st_r.state <= pfs_pkg::PFS_OFF;
         st_r.duty  <= pfs_pkg::DUTY_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_pwm_en               = st_r.pwm_en;
   assign o_pwm_duty             = st_r.duty;
   assign o_pwm_edge_fall        = st_r.edge_fall;
   assign o_pwm_sense_neg        = st_r.sense_neg;
   assign o_pulse_skip           = st_r.skip;
   assign o_sync_rectifier_drive = st_r.sr_on;
   assign o_sr_duty              = st_r.sr_duty;
   assign o_oring_switch         = st_r.oring;
   assign o_first_flag           = st_r.first;
   assign o_first_valid          = st_r.first_v;
   assign o_state                = st_r.state;
endmodule

// *** sim/pfs_stage_model.sv ***
`timescale 1ns/10ps
module pfs_stage_model (
   input  wire logic i_clk,      // system clock
   input  wire logic i_pwm_en,   // primary switching on
   input  wire logic i_short,    // output short applied
   output logic      o_ocp_flag  // input overcurrent flag
);
   // current only flows while the bridge switches into the short
   always_ff @(posedge i_clk) begin
      o_ocp_flag <= i_short & i_pwm_en;
   end
endmodule

// *** sim/pfs_sequencer_chk.sv ***
`timescale 1ns/10ps
module pfs_sequencer_chk (
   input  wire logic       i_clk,                   // clock
   input  wire logic       i_rst_b,                 // reset, active low
   input  wire logic       i_software_power_on_bit, // software request
   input  wire logic [1:0] i_pon_src,               // request source
   input  wire logic       i_sr_blank,              // rectifier blanking
   input  wire logic       i_fixed_en,              // fixed duty mode
   input  wire logic [7:0] i_fixed_duty,            // fixed duty value
   input  wire logic       i_first_clr,             // record clear
   input  wire logic       o_pwm_en,                // primary enabled
   input  wire logic [7:0] o_pwm_duty,              // primary duty
   input  wire logic       o_pulse_skip,            // skipping
   input  wire logic       o_sync_rectifier_drive,  // rectifiers on
   input  wire logic [7:0] o_first_flag,            // first flag
   input  wire logic       o_first_valid,           // record valid
   input  wire logic [2:0] o_state                  // sequencer state
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   a_request_taken: assert property (
      $rose(i_software_power_on_bit) && i_pon_src == 2'h2 && o_state == 3'h0 |-> ##[1:4] o_state != 3'h0)
      else $error("request not taken");
   a_off_quiet: assert property (
      o_state == 3'h0 && $past(o_state) == 3'h0 |-> !o_pwm_en && !o_sync_rectifier_drive)
      else $error("switching while off");
   a_soft_blank: assert property (
      o_state == 3'h2 && $past(o_state) == 3'h2 && i_sr_blank && $past(i_sr_blank) |-> !o_sync_rectifier_drive)
      else $error("rectifiers on while blanked");
   a_retry_quiet: assert property (
      o_state == 3'h4 && $past(o_state) == 3'h4 |-> !o_pwm_en)
      else $error("pwm on in retry");
   a_latch_quiet: assert property (
      o_state == 3'h5 && $past(o_state) == 3'h5 |-> !o_pwm_en)
      else $error("pwm on in latch");
   a_retry_hold: assert property (
      $rose(o_state == 3'h4) |-> (o_state == 3'h4) [*8])
      else $error("retry left early");
   a_skip_zero: assert property (
      o_pulse_skip |-> o_pwm_duty == 8'h00)
      else $error("duty while skipping");
   a_first_onehot: assert property (
      o_first_valid |-> $onehot(o_first_flag))
      else $error("first flag not one-hot");
   a_first_keep: assert property (
      $past(o_first_valid) && !$past(i_first_clr) |-> o_first_valid && $stable(o_first_flag))
      else $error("first flag record changed");
   a_fixed_duty: assert property (
      o_state == 3'h3 && $past(o_state, 2) == 3'h3 && i_fixed_en && $past(i_fixed_en, 2)
      && $past(i_fixed_duty, 2) == i_fixed_duty && !o_pulse_skip |-> o_pwm_duty == i_fixed_duty)
      else $error("fixed duty not applied");
   c_retry: cover property ($rose(o_state == 3'h4));
   c_latch: cover property ($rose(o_state == 3'h5));
   c_skip: cover property ($rose(o_pulse_skip));
endmodule
bind pfs_sequencer pfs_sequencer_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
   .i_software_power_on_bit(i_software_power_on_bit), .i_pon_src(i_pon_src), .i_sr_blank(i_sr_blank),
   .i_fixed_en(i_fixed_en), .i_fixed_duty(i_fixed_duty), .i_first_clr(i_first_clr), .o_pwm_en(o_pwm_en),
   .o_pwm_duty(o_pwm_duty), .o_pulse_skip(o_pulse_skip), .o_sync_rectifier_drive(o_sync_rectifier_drive),
   .o_first_flag(o_first_flag), .o_first_valid(o_first_valid), .o_state(o_state));

// *** sim/psu_fault_response_sequencer_test.sv ***
`timescale 1ns/10ps
module psu_fault_response_sequencer_test;
   logic        i_clk = 1'b0;
   logic        i_rst_b = 1'b0;
   logic [7:1]  flg = 7'h00;
   logic [15:0] act = 16'h00c3;
   logic [7:0]  dem = 8'h80;
   logic [1:0]  dsel = 2'h1;
   logic [7:0]  tim = 8'h03, rlat = 8'h08;
   logic [1:0]  psrc = 2'h2, sss = 2'h1;
   logic        hw = 1'b0, ssa = 1'b1;
   logic        sw = 1'b0, shrt = 1'b0, blank = 1'b1, srsoft = 1'b0, skip = 1'b0;
   logic        fix = 1'b0, edg = 1'b0, sen = 1'b0, fclr = 1'b0, overcurrent_flag;
   logic        pwm_en, pwm_ef, pwm_sn, pskip, o_sr, o_or, fval;
   logic [7:0]  duty, o_srd, first, d1;
   logic [2:0]  st;
   int          err_count = 0;
   int          n_tests = 0;
   int          n;
   always #5 i_clk = ~i_clk;
   pfs_stage_model u_stage (.i_clk(i_clk), .i_pwm_en(pwm_en), .i_short(shrt), .o_ocp_flag(overcurrent_flag));
   pfs_sequencer #(.TICK_CYC(1), .US_PER_MS(1)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_flag({flg, overcurrent_flag}),
      .i_action(act), .i_timing_imm(tim), .i_recovery_latch(rlat), .i_debounce(8'h14),
      .i_power_on_request(hw), .i_software_power_on_bit(sw), .i_pon_src(psrc), .i_pon_delay_sel(dsel),
      .i_ss_sel(sss), .i_sr_blank(blank), .i_sr_soft(srsoft), .i_ss_always(ssa), .i_duty_demand(dem),
      .i_mod_low(8'h20), .i_skip_en(skip), .i_fixed_en(fix), .i_fixed_duty(8'h5a), .i_edge_fall(edg),
      .i_sense_neg(sen), .i_first_clr(fclr), .o_pwm_en(pwm_en), .o_pwm_duty(duty), .o_pwm_edge_fall(pwm_ef),
      .o_pwm_sense_neg(pwm_sn), .o_pulse_skip(pskip), .o_sync_rectifier_drive(o_sr), .o_sr_duty(o_srd),
      .o_oring_switch(o_or), .o_first_flag(first), .o_first_valid(fval), .o_state(st));
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task cyc(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask
   task wait_st(input logic [2:0] s);
      n = 0;
      while (st !== s) begin
         cyc(1);
         n++;
         if (n > 3000) begin
            err_count++;
            $display("BAD state exp %0h seen %0h", s, st);
            print_verdict;
         end
      end
   endtask
   task t_start;
      sw = 1'b1;
      wait_st(3'h1);
      check("dly_enter", n <= 4, 1'b1);
      wait_st(3'h2);
      check("dly_500", n >= 495 && n <= 505, 1'b1);
      cyc(2);
      check("sr_blank", o_sr, 1'b0);
      check("pwm_soft", pwm_en, 1'b1);
      wait_st(3'h3);
      check("ramp_20", n >= 16 && n <= 23, 1'b1);
      cyc(2);
      check("or_run", o_or, 1'b1);
   endtask
   task t_act;
      for (int c = 0; c < 3; c++) begin
         act[3:2] = c[1:0];
         flg[1] = 1'b1;
         cyc(8);
         check("sr_act", o_sr, c != 1);
         check("or_act", o_or, c != 2);
         check("st_act", st, 3'h3);
         flg[1] = 1'b0;
         cyc(8);
      end
   endtask
   task t_db;
      fclr = 1'b1;
      cyc(1);
      fclr = 1'b0;
      flg[3] = 1'b1;
      cyc(5);
      flg[3] = 1'b0;
      cyc(30);
      check("short_pulse", st, 3'h3);
      check("no_first", fval, 1'b0);
      flg[3] = 1'b1;
      cyc(15);
      flg[3] = 1'b0;
      cyc(2);
      flg[3] = 1'b1;
      cyc(15);
      check("db_restart", st, 3'h3);
      wait_st(3'h5);
      check("db_len", n <= 12, 1'b1);
      check("first", first, 8'h08);
      check("first_v", fval, 1'b1);
      flg[3] = 1'b0;
      cyc(1200);
      check("latch_hold", st, 3'h5);
      sw = 1'b0;
      wait_st(3'h0);
      dsel = 2'h3;
      sw = 1'b1;
      wait_st(3'h1);
      wait_st(3'h2);
      check("dly_2000", n >= 1995 && n <= 2005, 1'b1);
      wait_st(3'h3);
   endtask
   task t_ocp;
      blank = 1'b0;
      srsoft = 1'b1;
      shrt = 1'b1;
      wait_st(3'h4);
      check("ocp_fast", n <= 8, 1'b1);
      shrt = 1'b0;
      cyc(2);
      check("ocp_pwm", pwm_en, 1'b0);
      wait_st(3'h2);
      check("retry_1s", n >= 990 && n <= 1005, 1'b1);
      cyc(3);
      d1 = o_srd;
      check("sr_soft_on", o_sr, 1'b1);
      cyc(12);
      check("sr_fade", o_srd > d1, 1'b1);
      wait_st(3'h3);
   endtask
   task t_pwm;
      edg = 1'b1;
      sen = 1'b1;
      cyc(3);
      check("edge", pwm_ef, 1'b1);
      check("sense", pwm_sn, 1'b1);
      skip = 1'b1;
      dem = 8'h10;
      cyc(3);
      check("skip", pskip, 1'b1);
      dem = 8'h80;
      fix = 1'b1;
      cyc(3);
      check("fixed", duty, 8'h5a);
      check("no_skip", pskip, 1'b0);
   endtask
   task t_hw;
      fix = 1'b0;
      dsel = 2'h0;
      sss = 2'h2;
      psrc = 2'h1;
      wait_st(3'h0);
      cyc(2);
      check("hw_off", pwm_en, 1'b0);
      hw = 1'b1;
      wait_st(3'h1);
      check("hw_sync", n >= 3 && n <= 5, 1'b1);
      wait_st(3'h3);
      check("ramp_40", n >= 38 && n <= 45, 1'b1);
      ssa = 1'b0;
      shrt = 1'b1;
      wait_st(3'h4);
      shrt = 1'b0;
      cyc(1005);
      check("direct_run", st, 3'h3);
      rlat = 8'h09;
      tim = 8'h02;
      shrt = 1'b1;
      wait_st(3'h5);
      check("ocp_db", n >= 22 && n <= 28, 1'b1);
      shrt = 1'b0;
      cyc(20);
      check("ocp_latch", st, 3'h5);
      hw = 1'b0;
      wait_st(3'h0);
      check("latch_rel", n <= 5, 1'b1);
   endtask
   initial begin
      repeat (2) @(posedge i_clk);
      #1 i_rst_b = 1'b1;
      t_start;
      t_act;
      t_db;
      t_ocp;
      t_pwm;
      t_hw;
      print_verdict;
   end
endmodule
